// ### rtl/ssr_pkg.sv
// Constants and types shared by the sequential-read serial memory block.
`default_nettype none
package ssr_pkg;
    localparam int          ADDR_W    = 10;
    localparam int          DATA_W    = 8;
    localparam int          MEM_DEPTH = 1024;
    localparam logic [9:0]  LAST_ADDR = 10'h3FF;
    localparam logic [9:0]  ADDR_RST  = 10'h000;
    localparam logic [9:0]  ADDR_STEP = 10'h001;
    localparam logic [2:0]  BIT_FIRST = 3'h0;
    localparam logic [2:0]  BIT_LAST  = 3'h7;
    localparam logic [2:0]  BIT_STEP  = 3'h1;
    localparam int          SYNC_W    = 2;
    localparam int          SCL_BIT   = 0;
    localparam int          SDA_BIT   = 1;

    typedef enum logic [1:0] {
        SSR_IDLE = 2'b00,
        SSR_SEND = 2'b01,
        SSR_ACKW = 2'b11,
        SSR_HALT = 2'b10
    } ssr_state_t;
endpackage
`default_nettype wire

// ### rtl/ssr_seq_read.sv
// Sequential-read engine of a 1024-byte two-wire serial memory slave.
//
// Function
// - Reads start as current-address or random read; first byte sent normally.
// - On each master acknowledge the device sends the next memory byte.
// - Bytes of one read come from consecutive addresses n, n plus one.
// - Read counter increments across all address bits.
// - After location 1023 the counter wraps to 0 and output continues.
// - Counter holds last accessed location plus one; current reads start there.
// - Without acknowledge, stop sending and release data until a stop.
`default_nettype none
module ssr_seq_read
    import ssr_pkg::*;
(
    input  wire logic              clk,
    input  wire logic              reset_n,
    input  wire logic              ce,
    input  wire logic              scl_in,
    input  wire logic              sda_in,
    output logic                   sda_out,
    output logic                   sda_oe,
    input  wire logic              read_go,
    input  wire logic              stop_seen,
    input  wire logic              addr_load,
    input  wire logic [ADDR_W-1:0] addr_value,
    input  wire logic              mem_we,
    input  wire logic [ADDR_W-1:0] mem_waddr,
    input  wire logic [DATA_W-1:0] mem_wdata,
    output logic      [ADDR_W-1:0] addr_count,
    output logic                   busy,
    output logic                   halted
);
    // ------------------------------------------------------------------
    // Pin synchronisation and clock edge detection
    // ------------------------------------------------------------------
    // Both pins pass two flip-flops, so every detected clock edge lags the
    // pin by two to three cycles; at 20 MHz that is a small part of a bit.
    logic [SYNC_W-1:0] pins_sync;
    logic              scl_prev;
    wire logic         scl_s  = pins_sync[SCL_BIT];
    wire logic         sda_s  = pins_sync[SDA_BIT];
    wire logic         scl_rise = scl_s & ~scl_prev;
    wire logic         scl_fall = ~scl_s & scl_prev;

    ssr_sync #(
        .WIDTH (SYNC_W)
    ) u_sync (
        .clk      (clk),
        .reset_n  (reset_n),
        .ce       (ce),
        .async_in ({sda_in, scl_in}),
        .sync_out (pins_sync)
    );

    // The previous level resets high, the idle level of the pin, so no
    // false fall is seen when reset ends.
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            scl_prev <= 1'b1;
        end else if (ce) begin
            scl_prev <= scl_s;
        end
    end

    // ------------------------------------------------------------------
    // State, decoding and next values
    // ------------------------------------------------------------------
    logic [DATA_W-1:0] mem [MEM_DEPTH];
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] shift;
    logic [2:0]        bit_cnt;
    logic              ack_seen;
    ssr_state_t        state;
    ssr_state_t        next_state;

    // The full-width add wraps 1023 to 0 with no extra logic.
    wire logic [ADDR_W-1:0] addr_inc   = addr + ADDR_STEP;
    wire logic [ADDR_W-1:0] wr_inc     = mem_waddr + ADDR_STEP;
    wire logic [DATA_W-1:0] rd_data    = mem[addr];
    wire logic              start_byte = (state == SSR_IDLE) & read_go;
    wire logic              next_byte  = (state == SSR_ACKW) & ack_seen
                                         & scl_fall;
    wire logic              load_byte  = start_byte | next_byte;
    wire logic              last_bit   = (bit_cnt == BIT_LAST);
    wire logic              shift_step = (state == SSR_SEND) & scl_fall
                                         & ~last_bit;
    wire logic [DATA_W-1:0] next_shift = {shift[DATA_W-2:0], 1'b0};

    // A byte fetch wins over a write, and a write over a word address load.
    // The status copy takes the same next value, so it never lags the
    // counter that the following fetch will use.
    wire logic [ADDR_W-1:0] next_addr  = load_byte ? addr_inc
                                       : mem_we    ? wr_inc
                                       : addr_load ? addr_value
                                       : addr;

    // ------------------------------------------------------------------
    // Storage
    // ------------------------------------------------------------------
    // Reset leaves the array alone, so stored bytes outlive a reset of
    // the engine, as a nonvolatile array would.
    always_ff @(posedge clk) begin
        if (ce && mem_we) begin
            mem[mem_waddr] <= mem_wdata;
        end
    end

    // ------------------------------------------------------------------
    // Address counter
    // ------------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            addr <= ADDR_RST;
        end else if (ce) begin
            addr <= next_addr;
        end
    end

    // ------------------------------------------------------------------
    // Transmit state machine
    // ------------------------------------------------------------------
    always_comb begin
        next_state = state;
        case (state)
            SSR_IDLE: begin
                if (read_go) begin
                    next_state = SSR_SEND;
                end
            end
            SSR_SEND: begin
                if (scl_fall && last_bit) begin
                    next_state = SSR_ACKW;
                end
            end
            SSR_ACKW: begin
                if (scl_rise && sda_s) begin
                    next_state = SSR_HALT;
                end else if (next_byte) begin
                    next_state = SSR_SEND;
                end
            end
            SSR_HALT: begin
                // Every clock edge is ignored here; only a stop ends it.
                next_state = SSR_HALT;
            end
            default: begin
                next_state = SSR_IDLE;
            end
        endcase
        if (stop_seen) begin
            next_state = SSR_IDLE;
        end
    end

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            state <= SSR_IDLE;
        end else if (ce) begin
            state <= next_state;
        end
    end

    // Acknowledge is sampled on the ninth rising edge, used on its fall.
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            ack_seen <= 1'b0;
        end else if (ce) begin
            if (state != SSR_ACKW) begin
                ack_seen <= 1'b0;
            end else if (scl_rise) begin
                ack_seen <= ~sda_s;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            shift   <= '0;
            bit_cnt <= BIT_FIRST;
        end else if (ce) begin
            if (load_byte) begin
                shift   <= rd_data;
                bit_cnt <= BIT_FIRST;
            end else if (shift_step) begin
                shift   <= next_shift;
                bit_cnt <= bit_cnt + BIT_STEP;
            end
        end
    end

    // ------------------------------------------------------------------
    // Pin drive and status
    // ------------------------------------------------------------------
    // The line is only ever pulled low; a one is sent by releasing it.
    wire logic [DATA_W-1:0] tx_byte = load_byte ? rd_data : shift;
    wire logic              tx_bit  = shift_step ? shift[DATA_W-2]
                                                 : tx_byte[DATA_W-1];
    wire logic              drive   = (next_state == SSR_SEND) & ~tx_bit;

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            sda_out    <= 1'b0;
            sda_oe     <= 1'b0;
            addr_count <= ADDR_RST;
            busy       <= 1'b0;
            halted     <= 1'b0;
        end else if (ce) begin
            sda_out    <= 1'b0;
            sda_oe     <= drive;
            addr_count <= next_addr;
            busy       <= next_state != SSR_IDLE;
            halted     <= next_state == SSR_HALT;
        end
    end
endmodule
`default_nettype wire

// ### rtl/ssr_sync.sv
// Two-flip-flop synchroniser for pin inputs.
`default_nettype none
module ssr_sync #(
    parameter int WIDTH = 2
) (
    input  wire logic             clk,
    input  wire logic             reset_n,
    input  wire logic             ce,
    input  wire logic [WIDTH-1:0] async_in,
    output logic      [WIDTH-1:0] sync_out
);
    logic [WIDTH-1:0] meta;

    // Pins idle high on an open-drain bus, so both stages reset high.
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            meta     <= '1;
            sync_out <= '1;
        end else if (ce) begin
            meta     <= async_in;
            sync_out <= meta;
        end
    end
endmodule
`default_nettype wire

// ### verification/ssr_master_model.sv
// Behavioural two-wire bus master that clocks read bytes out of the slave.
`default_nettype none
module ssr_master_model (
    input  wire logic       go,
    input  wire logic [3:0] nbytes,
    input  wire logic       sda,
    output logic            scl,
    output logic            pull,
    output logic [7:0]      rx_byte,
    output logic            rx_tog
);
    timeunit 1ns;
    timeprecision 1ns;
    // ----
    // The clock stands high outside frames; it runs only inside one.
    // ----
    initial begin
        scl = 1'b1;
        pull = 1'b0;
        rx_byte = 8'h00;
        rx_tog = 1'b0;
        forever begin
            @(posedge go);
            scl = 1'b0;
            #400;
            for (int n = 1; n <= int'(nbytes); n++) begin
                for (int b = 0; b < 9; b++) begin
                    pull = (b == 8) && (n < int'(nbytes));
                    #200 scl = 1'b1;
                    if (b < 8) rx_byte = {rx_byte[6:0], sda};
                    #200 scl = 1'b0;
                end
                pull = 1'b0;
                rx_tog = ~rx_tog;
            end
            #200 scl = 1'b1;
        end
    end
endmodule
`default_nettype wire

// ### verification/ssr_seq_read_asserts.sv
// Concurrent checks on the ports of the sequential-read engine.
`default_nettype none
module ssr_seq_read_asserts
    import ssr_pkg::*;
(
    input wire logic              clk,
    input wire logic              reset_n,
    input wire logic              ce,
    input wire logic              sda_out,
    input wire logic              sda_oe,
    input wire logic              read_go,
    input wire logic              stop_seen,
    input wire logic              addr_load,
    input wire logic [ADDR_W-1:0] addr_value,
    input wire logic              mem_we,
    input wire logic [ADDR_W-1:0] mem_waddr,
    input wire logic [ADDR_W-1:0] addr_count,
    input wire logic              busy,
    input wire logic              halted
);
    default clocking cb @(posedge clk);
    endclocking
    // A frozen cycle advances nothing, so checks pause while ce is low.
    default disable iff (!reset_n || !ce);
    sequence s_start;
        !busy && read_go && !stop_seen;
    endsequence
    sequence s_sending;
        busy && !halted;
    endsequence
    a_go_sends:
    assert property (s_start |=> s_sending)
        else $error("read start left the engine idle");
    a_go_count:
    assert property (s_start |=> addr_count == $past(addr_count) + ADDR_STEP)
        else $error("first fetch did not advance the counter");
    a_count_step:
    assert property ($past(busy) && !$past(mem_we) && !$past(addr_load)
        && $changed(addr_count) |-> addr_count == $past(addr_count) + ADDR_STEP)
        else $error("read counter moved by other than one");
    a_load_count:
    assert property (addr_load && !busy && !mem_we && !read_go
        |=> addr_count == $past(addr_value))
        else $error("word address not loaded");
    a_write_count:
    assert property (mem_we && !busy && !read_go
        |=> addr_count == $past(mem_waddr) + ADDR_STEP)
        else $error("write did not leave counter at address plus one");
    a_halt_quiet:
    assert property (halted |-> !sda_oe && !sda_out)
        else $error("data line driven while halted");
    a_halt_holds:
    assert property (halted && !stop_seen |=> halted)
        else $error("halt left without a stop");
    a_stop_idle:
    assert property (stop_seen |=> !busy && !halted && !sda_oe)
        else $error("stop did not return the engine to idle");
endmodule
bind ssr_seq_read ssr_seq_read_asserts i_chk (.clk, .reset_n, .ce, .sda_out,
    .sda_oe, .read_go, .stop_seen, .addr_load, .addr_value, .mem_we,
    .mem_waddr, .addr_count, .busy, .halted);
`default_nettype wire

// ### verification/test_ssr_seq_read.sv
// Self-checking bench of the sequential-read engine.
`default_nettype none
module test_ssr_seq_read import ssr_pkg::*;;
    timeunit 1ns;
    timeprecision 1ns;
    logic              clk = 1'b0;
    logic              reset_n = 1'b0;
    logic              read_go = 1'b0;
    logic              stop_seen = 1'b0;
    logic              addr_load = 1'b0;
    logic              mem_we = 1'b0;
    logic              ce = 1'b1;
    logic              go = 1'b0;
    logic [3:0]        nbytes = 4'h0;
    logic [ADDR_W-1:0] addr_value = 10'h000;
    logic [ADDR_W-1:0] mem_waddr = 10'h000;
    logic [DATA_W-1:0] mem_wdata = 8'h00;
    logic [31:0]       seed = 32'h00000035;
    logic [DATA_W-1:0] exp_mem [MEM_DEPTH];
    logic [DATA_W-1:0] exp_q [$];
    logic [ADDR_W-1:0] addr_count;
    logic [7:0]        rx_byte;
    logic              scl, pull, rx_tog, sda_out, sda_oe, busy, halted;
    wire logic         sda_line;
    int                bad_count = 0;
    int                total_checks = 0;
    // ----
    // The data line has a pull-up: it is low only while someone pulls it.
    // ----
    assign sda_line = ~(sda_oe | pull);
    ssr_seq_read i_dut (.clk, .reset_n, .ce, .scl_in(scl),
        .sda_in(sda_line), .sda_out, .sda_oe, .read_go, .stop_seen,
        .addr_load, .addr_value, .mem_we, .mem_waddr, .mem_wdata,
        .addr_count, .busy, .halted);
    ssr_master_model i_mst (.go, .nbytes, .sda(sda_line), .scl, .pull,
        .rx_byte, .rx_tog);
    initial forever #25 clk = ~clk;
    function automatic logic [31:0] xs(input logic [31:0] s);
        s = s ^ (s << 13);
        s = s ^ (s >> 17);
        return s ^ (s << 5);
    endfunction
    task automatic chk_byte(input logic [7:0] e, input logic [7:0] s);
        total_checks++;
        if (s !== e) begin
            bad_count++;
            $display("BAD rx_byte exp %h got %h", e, s);
        end
    endtask
    task automatic chk_val(input string nm, input logic [9:0] e, s);
        total_checks++;
        if (s !== e) begin
            bad_count++;
            $display("BAD %s exp %h got %h", nm, e, s);
        end
    endtask
    task automatic summarize;
        $display("checks %0d bad %0d", total_checks, bad_count);
        if (bad_count == 0 && total_checks > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    always @(rx_tog) begin
        if (reset_n === 1'b1) chk_byte(exp_q.pop_front(), rx_byte);
    end
    task automatic rd(input logic [9:0] a, input logic [3:0] n);
        go = 1'b1;
        nbytes = n;
        for (int i = 0; i < int'(n); i++) exp_q.push_back(exp_mem[a + 10'(i)]);
        repeat (3) @(negedge clk);
        read_go = 1'b1;
        @(negedge clk);
        read_go = 1'b0;
        go = 1'b0;
        for (int i = 0; i < 2000 && exp_q.size() > 0; i++) @(negedge clk);
        if (exp_q.size() > 0) bad_count++;
        if (exp_q.size() > 0) summarize();
        repeat (16) @(negedge clk);
        chk_val("halted", 10'h001, 10'(halted));
        chk_val("sda_oe", 10'h000, 10'(sda_oe));
        chk_val("addr_count", a + 10'(n), addr_count);
        stop_seen = 1'b1;
        @(negedge clk);
        stop_seen = 1'b0;
        @(negedge clk);
        chk_val("busy", 10'h000, 10'(busy));
    endtask
    initial begin
        repeat (10) @(negedge clk);
        reset_n = 1'b1;
        for (int i = 0; i < 8; i++) begin
            seed = xs(seed);
            mem_we = 1'b1;
            mem_waddr = 10'h3FC + 10'(i);
            mem_wdata = seed[7:0];
            exp_mem[mem_waddr] = seed[7:0];
            @(negedge clk);
        end
        mem_we = 1'b0;
        @(negedge clk);
        chk_val("addr_count", 10'h004, addr_count);
        addr_load = 1'b1;
        addr_value = 10'h3FD;
        @(negedge clk);
        addr_load = 1'b0;
        @(negedge clk);
        chk_val("addr_count", 10'h3FD, addr_count);
        ce = 1'b0;
        addr_load = 1'b1;
        addr_value = 10'h155;
        @(negedge clk);
        addr_load = 1'b0;
        ce = 1'b1;
        @(negedge clk);
        chk_val("addr_count", 10'h3FD, addr_count);
        rd(10'h3FD, 4'h6);
        rd(10'h003, 4'h1);
        summarize();
    end
endmodule
`default_nettype wire
